// ===== include/pudc_pkg.sv
// package: constants, register map and pin carriers of the presettable up/down counter
// ----------------------------------------------------------------------------
// Function
// - load high copies the four preset bits into the count.
// - load acts at once, without waiting for a clock edge.
// - direction high counts up, low counts down on each counting edge.
// - count steps only on a rising clock edge with counting enabled.
// - clear high forces the count to zero, above every other input.
// - carry-out feeds the next stage's carry-in; all stages share one clock.
// - counting up, carry-out is low only at all ones with carry-in low.
// - counting down, carry-out is low only at all zeros with carry-in low.
// - clock ignored while carry-in is high, or load or clear is high.
// - count shown in plain binary, bit 0 least significant.
// - carry-out low one cycle at 15 up or 0 down when counting; for as long as a held load or clear shows that count.
// ----------------------------------------------------------------------------
package pudc_pkg;
   // ----------------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------------
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   localparam logic [CNT_W-1:0] CNT_ALL = 4'hf;
   localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
   // ----------------------------------------------------------------------
   // register map, byte addresses
   // ----------------------------------------------------------------------
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   localparam logic [ADR_W-1:0] ADR_CTRL = 8'h00;
   localparam logic [ADR_W-1:0] ADR_STAT = 8'h04;
   localparam logic [ADR_W-1:0] ADR_IRQ_STAT = 8'h08;
   localparam logic [ADR_W-1:0] ADR_IRQ_MASK = 8'h0c;
   localparam logic [ADR_W-1:0] ADR_COUNT = 8'h10;
   localparam logic [DAT_W-1:0] DAT_ZERO = 32'h0000_0000;
   // control fields
   localparam int CTRL_RUN_BIT = 0;
   localparam logic CTRL_RUN_RST = 1'h1;
   // status fields
   localparam int STAT_CARRY_BIT = 0;
   localparam int STAT_DIR_BIT = 1;
   localparam int STAT_LOAD_BIT = 2;
   localparam int STAT_CLR_BIT = 3;
   localparam int STAT_CIN_BIT = 4;
   // interrupt fields
   localparam int IRQ_W = 3;
   localparam int IRQ_TERM_BIT = 0;
   localparam int IRQ_LOAD_BIT = 1;
   localparam int IRQ_CLR_BIT = 2;
   localparam logic [IRQ_W-1:0] IRQ_ZERO = 3'h0;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
   // ----------------------------------------------------------------------
   // pin carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic load_enable;
      logic counter_clear;
      logic up_count;
      logic carry_in_n;
      logic preset_bit_3;
      logic preset_bit_2;
      logic preset_bit_1;
      logic preset_bit_0;
   } pudc_pins_in_t;
   typedef struct packed {
      logic carry_out_n;
      logic count_bit_3;
      logic count_bit_2;
      logic count_bit_1;
      logic count_bit_0;
   } pudc_pins_out_t;
endpackage

// ===== core/pudc_count_core.sv
// module: four-bit count state with clear, load and up/down step
`timescale 1ns/1ps
`default_nettype none
module pudc_count_core (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // control
   input wire logic counter_clear,
   input wire logic load_enable,
   input wire logic [pudc_pkg::CNT_W-1:0] preset,
   input wire logic up_count,
   input wire logic count_enable,
   // state
   output logic [pudc_pkg::CNT_W-1:0] count_q
);
   typedef struct packed {
      logic [pudc_pkg::CNT_W-1:0] count;
   } pudc_core_st_t;

   pudc_core_st_t st_reg;
   pudc_core_st_t st_next;

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      if (counter_clear) begin
         st_next.count = pudc_pkg::CNT_ZERO;
      end else if (load_enable) begin
         st_next.count = preset;
      end else if (count_enable) begin
         // four-bit sum drops the carry, giving the wrap
         if (up_count) begin
            st_next.count = st_reg.count + pudc_pkg::CNT_ONE;
         end else begin
            st_next.count = st_reg.count - pudc_pkg::CNT_ONE;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '{count: pudc_pkg::CNT_RST};
      end else begin
         st_reg <= st_next;
      end
   end

   assign count_q = st_reg.count;
endmodule // pudc_count_core
`default_nettype wire

// ===== core/pudc_irq_bank.sv
// module: sticky interrupt status bits, write-one-to-clear, masked level output
`timescale 1ns/1ps
`default_nettype none
module pudc_irq_bank (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // events and software access
   input wire logic [pudc_pkg::IRQ_W-1:0] event_set,
   input wire logic clr_wr,
   input wire logic [pudc_pkg::IRQ_W-1:0] clr_data,
   input wire logic [pudc_pkg::IRQ_W-1:0] mask,
   // results
   output logic [pudc_pkg::IRQ_W-1:0] status,
   output logic irq
);
   typedef struct packed {
      logic [pudc_pkg::IRQ_W-1:0] stat;
   } pudc_irq_st_t;

   pudc_irq_st_t st_reg;
   pudc_irq_st_t st_next;
   logic [pudc_pkg::IRQ_W-1:0] stat_bit_next;

   // ------------------------------------------------------------------
   // per bit: an event in the clearing cycle wins over the clear
   // ------------------------------------------------------------------
   for (genvar i = 0; i < pudc_pkg::IRQ_W; i++) begin : g_bit
      assign stat_bit_next[i] = event_set[i] | (st_reg.stat[i] & ~(clr_wr & clr_data[i]));
   end

   always_comb begin
      st_next = st_reg;
      st_next.stat = stat_bit_next;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '{stat: pudc_pkg::IRQ_ZERO};
      end else begin
         st_reg <= st_next;
      end
   end

   assign status = st_reg.stat;
   assign irq = |(st_reg.stat & mask);
endmodule // pudc_irq_bank
`default_nettype wire

// ===== core/pudc_counter.sv
// module: presettable up/down binary counter with a classic wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module pudc_counter (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [pudc_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [pudc_pkg::DAT_W-1:0] wb_dat_i,
   output logic [pudc_pkg::DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   // counter pins, same clock as the controlling logic
   input wire pudc_pkg::pudc_pins_in_t pins_i,
   output pudc_pkg::pudc_pins_out_t pins_o,
   // interrupt
   output logic irq
);
   typedef struct packed {
      logic ack;
      logic [pudc_pkg::DAT_W-1:0] rdata;
      logic run;
      logic [pudc_pkg::IRQ_W-1:0] mask;
   } pudc_top_st_t;

   pudc_top_st_t st_reg;
   pudc_top_st_t st_next;

   logic [pudc_pkg::CNT_W-1:0] preset_vec;
   logic [pudc_pkg::CNT_W-1:0] count_q;
   logic [pudc_pkg::CNT_W-1:0] count_shown;
   logic carry_in_eff_n;
   logic count_enable;
   logic terminal;
   logic carry_out_n;
   logic load_active;
   logic [pudc_pkg::IRQ_W-1:0] event_set;
   logic [pudc_pkg::IRQ_W-1:0] irq_status;
   logic bus_req;
   logic bus_take;
   logic bus_wr;
   logic [pudc_pkg::DAT_W-1:0] rd_mux;

   // ------------------------------------------------------------------
   // counting control
   // ------------------------------------------------------------------
   assign preset_vec = {pins_i.preset_bit_3, pins_i.preset_bit_2, pins_i.preset_bit_1, pins_i.preset_bit_0};
   // a stopped run bit acts like a high carry-in, so a chain stays consistent
   assign carry_in_eff_n = pins_i.carry_in_n | ~st_reg.run;
   assign load_active = pins_i.load_enable & ~pins_i.counter_clear;
   assign count_enable = ~pins_i.load_enable & ~pins_i.counter_clear & ~carry_in_eff_n;

   pudc_count_core u_core (
      .clk(clk),
      .sys_rst(sys_rst),
      .counter_clear(pins_i.counter_clear),
      .load_enable(pins_i.load_enable),
      .preset(preset_vec),
      .up_count(pins_i.up_count),
      .count_enable(count_enable),
      .count_q(count_q)
   );

   // ------------------------------------------------------------------
   // outputs: clear and load bypass the register so they act at once
   // ------------------------------------------------------------------
   always_comb begin
      if (pins_i.counter_clear) begin
         count_shown = pudc_pkg::CNT_ZERO;
      end else if (pins_i.load_enable) begin
         count_shown = preset_vec;
      end else begin
         count_shown = count_q;
      end
   end

   // terminal count depends on direction; no register, so carry-in ripples through
   assign terminal = pins_i.up_count ? (count_shown == pudc_pkg::CNT_ALL)
                                     : (count_shown == pudc_pkg::CNT_ZERO);
   assign carry_out_n = ~(terminal & ~carry_in_eff_n);

   assign pins_o.carry_out_n = carry_out_n;
   assign pins_o.count_bit_3 = count_shown[3];
   assign pins_o.count_bit_2 = count_shown[2];
   assign pins_o.count_bit_1 = count_shown[1];
   assign pins_o.count_bit_0 = count_shown[0];

   // ------------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------------
   always_comb begin
      event_set = pudc_pkg::IRQ_ZERO;
      event_set[pudc_pkg::IRQ_TERM_BIT] = count_enable & ~carry_out_n;
      event_set[pudc_pkg::IRQ_LOAD_BIT] = load_active;
      event_set[pudc_pkg::IRQ_CLR_BIT] = pins_i.counter_clear;
   end

   pudc_irq_bank u_irq (
      .clk(clk),
      .sys_rst(sys_rst),
      .event_set(event_set),
      .clr_wr(bus_wr & (wb_adr_i == pudc_pkg::ADR_IRQ_STAT)),
      .clr_data(wb_dat_i[pudc_pkg::IRQ_W-1:0]),
      .mask(st_reg.mask),
      .status(irq_status),
      .irq(irq)
   );

   // ------------------------------------------------------------------
   // wishbone slave: one wait state, ack drops the cycle after it rose
   // ------------------------------------------------------------------
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign bus_take = bus_req & ~st_reg.ack;
   // all fields live in byte lane 0, so only sel[0] enables a write
   assign bus_wr = bus_take & wb_we_i & wb_sel_i[0];

   always_comb begin
      rd_mux = pudc_pkg::DAT_ZERO;
      unique case (wb_adr_i)
         pudc_pkg::ADR_CTRL: begin
            rd_mux[pudc_pkg::CTRL_RUN_BIT] = st_reg.run;
         end
         pudc_pkg::ADR_STAT: begin
            rd_mux[pudc_pkg::STAT_CARRY_BIT] = carry_out_n;
            rd_mux[pudc_pkg::STAT_DIR_BIT] = pins_i.up_count;
            rd_mux[pudc_pkg::STAT_LOAD_BIT] = pins_i.load_enable;
            rd_mux[pudc_pkg::STAT_CLR_BIT] = pins_i.counter_clear;
            rd_mux[pudc_pkg::STAT_CIN_BIT] = pins_i.carry_in_n;
         end
         pudc_pkg::ADR_IRQ_STAT: begin
            rd_mux[pudc_pkg::IRQ_W-1:0] = irq_status;
         end
         pudc_pkg::ADR_IRQ_MASK: begin
            rd_mux[pudc_pkg::IRQ_W-1:0] = st_reg.mask;
         end
         pudc_pkg::ADR_COUNT: begin
            rd_mux[pudc_pkg::CNT_W-1:0] = count_shown;
         end
         default: begin
            rd_mux = pudc_pkg::DAT_ZERO;
         end
      endcase
   end

   always_comb begin
      st_next = st_reg;
      st_next.ack = bus_take;
      if (bus_take) begin
         st_next.rdata = rd_mux;
      end
      if (bus_wr && (wb_adr_i == pudc_pkg::ADR_CTRL)) begin
         st_next.run = wb_dat_i[pudc_pkg::CTRL_RUN_BIT];
      end
      if (bus_wr && (wb_adr_i == pudc_pkg::ADR_IRQ_MASK)) begin
         st_next.mask = wb_dat_i[pudc_pkg::IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '{ack: 1'b0, rdata: pudc_pkg::DAT_ZERO, run: pudc_pkg::CTRL_RUN_RST,
                     mask: pudc_pkg::IRQ_MASK_RST};
      end else begin
         st_reg <= st_next;
      end
   end

   assign wb_ack_o = st_reg.ack;
   assign wb_dat_o = st_reg.rdata;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   logic [pudc_pkg::CNT_W-1:0] pin_count;
   assign pin_count = {pins_o.count_bit_3, pins_o.count_bit_2, pins_o.count_bit_1, pins_o.count_bit_0};

   load_shows_preset_a: assert property (
      (pins_i.load_enable && !pins_i.counter_clear) |-> (pin_count == preset_vec))
      else $error("preset not on the outputs while load is high");

   load_stores_a: assert property (
      (pins_i.load_enable && !pins_i.counter_clear) |=> (count_q == $past(preset_vec)))
      else $error("preset not held after load");

   up_step_a: assert property (
      (count_enable && pins_i.up_count && count_q != pudc_pkg::CNT_ALL)
      |=> (count_q == $past(count_q) + pudc_pkg::CNT_ONE))
      else $error("up count did not step by one");

   down_step_a: assert property (
      (count_enable && !pins_i.up_count && count_q != pudc_pkg::CNT_ZERO)
      |=> (count_q == $past(count_q) - pudc_pkg::CNT_ONE))
      else $error("down count did not step by one");

   wrap_up_a: assert property (
      (count_enable && pins_i.up_count && count_q == pudc_pkg::CNT_ALL) |=> (count_q == pudc_pkg::CNT_ZERO))
      else $error("up count did not wrap to zero");

   wrap_down_a: assert property (
      (count_enable && !pins_i.up_count && count_q == pudc_pkg::CNT_ZERO) |=> (count_q == pudc_pkg::CNT_ALL))
      else $error("down count did not wrap to all ones");

   count_hold_a: assert property (
      (pins_i.carry_in_n && !pins_i.load_enable && !pins_i.counter_clear) |=> $stable(count_q))
      else $error("count moved while carry-in was high");

   clear_wins_a: assert property (
      pins_i.counter_clear |-> (pin_count == pudc_pkg::CNT_ZERO) ##1 (count_q == pudc_pkg::CNT_ZERO))
      else $error("clear did not force zero");

   carry_up_a: assert property (
      (pins_i.up_count && !pins_i.carry_in_n && st_reg.run && pin_count == pudc_pkg::CNT_ALL
       && !pins_i.load_enable && !pins_i.counter_clear) |-> !pins_o.carry_out_n)
      else $error("carry-out not low at all ones counting up");

   carry_down_a: assert property (
      (!pins_i.up_count && pin_count != pudc_pkg::CNT_ZERO) |-> pins_o.carry_out_n)
      else $error("carry-out low away from zero counting down");

   carry_cin_a: assert property (
      pins_i.carry_in_n |-> pins_o.carry_out_n)
      else $error("carry-out low while carry-in is high");

   carry_one_cycle_a: assert property (
      (count_enable && !pins_o.carry_out_n) ##1 (count_enable && pins_i.up_count == $past(pins_i.up_count))
      |-> pins_o.carry_out_n)
      else $error("carry-out low for more than one counting cycle");

   irq_set_wins_a: assert property (
      event_set[pudc_pkg::IRQ_TERM_BIT] |=> irq_status[pudc_pkg::IRQ_TERM_BIT])
      else $error("terminal event lost in its status bit");

   bus_ack_a: assert property (
      (bus_req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not a single cycle after one wait state");

   // ------------------------------------------------------------------
   // carry and run gate
   // ------------------------------------------------------------------
   carry_up_high_a: assert property (
      (pins_i.up_count && pin_count != pudc_pkg::CNT_ALL) |-> pins_o.carry_out_n)
      else $error("carry-out low away from all ones counting up");

   carry_down_low_a: assert property (
      (!pins_i.up_count && !pins_i.carry_in_n && st_reg.run && pin_count == pudc_pkg::CNT_ZERO
       && !pins_i.load_enable && !pins_i.counter_clear) |-> !pins_o.carry_out_n)
      else $error("carry-out not low at zero counting down");

   run_gates_carry_a: assert property (
      !st_reg.run |-> pins_o.carry_out_n)
      else $error("carry-out low while the counter is stopped");

   // a stopped counter must hold even with carry-in low, or a chain would slip
   run_gates_count_a: assert property (
      (!st_reg.run && !pins_i.load_enable && !pins_i.counter_clear) |=> $stable(count_q))
      else $error("count moved while the counter is stopped");

   // ------------------------------------------------------------------
   // register side
   // ------------------------------------------------------------------
   // a clear that meets no event in its cycle must leave the bit low
   irq_w1c_a: assert property (
      (bus_wr && wb_adr_i == pudc_pkg::ADR_IRQ_STAT && wb_dat_i[pudc_pkg::IRQ_LOAD_BIT]
       && !event_set[pudc_pkg::IRQ_LOAD_BIT]) |=> !irq_status[pudc_pkg::IRQ_LOAD_BIT])
      else $error("load status bit not cleared by a one");

   mask_write_a: assert property (
      (bus_wr && wb_adr_i == pudc_pkg::ADR_IRQ_MASK)
      |=> (st_reg.mask == $past(wb_dat_i[pudc_pkg::IRQ_W-1:0])))
      else $error("mask write did not land");

   run_write_a: assert property (
      (bus_wr && wb_adr_i == pudc_pkg::ADR_CTRL)
      |=> (st_reg.run == $past(wb_dat_i[pudc_pkg::CTRL_RUN_BIT])))
      else $error("run bit write did not land");

   sel_blocks_a: assert property (
      (bus_take && wb_we_i && !wb_sel_i[0]) |=> ($stable(st_reg.mask) && $stable(st_reg.run)))
      else $error("write with lane 0 disabled changed a register");

   read_count_a: assert property (
      (bus_take && !wb_we_i && wb_adr_i == pudc_pkg::ADR_COUNT)
      |=> (wb_dat_o[pudc_pkg::CNT_W-1:0] == $past(count_shown)))
      else $error("count read back wrong");

   ack_idle_a: assert property (
      !bus_req |=> !wb_ack_o)
      else $error("bus ack without a request");

   up_wrap_c: cover property (
      (count_enable && pins_i.up_count && count_q == pudc_pkg::CNT_ALL) ##1 (count_q == pudc_pkg::CNT_ZERO));
   down_wrap_c: cover property (
      (count_enable && !pins_i.up_count && count_q == pudc_pkg::CNT_ZERO) ##1 (count_q == pudc_pkg::CNT_ALL));
   load_then_count_c: cover property (
      load_active ##1 count_enable ##1 count_enable);
   irq_raised_c: cover property (!irq ##1 irq);
   run_stop_c: cover property (!st_reg.run && !pins_i.carry_in_n);
endmodule // pudc_counter
`default_nettype wire

// ===== testbench/pudc_next_stage.sv
// file: behavioural next cascaded counter stage fed by the counter's carry-out
`timescale 1ns/1ps
`default_nettype none
module pudc_next_stage (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // cascade
   input wire logic carry_in_n,
   input wire logic up_count,
   input wire logic counter_clear,
   output logic [3:0] count
);
   // ---------------------------------------------------------------
   // stage
   // ---------------------------------------------------------------
   // same clock as the first stage; steps only while its carry is low
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) count <= 4'h0;
      else if (counter_clear) count <= 4'h0;
      else if (!carry_in_n) count <= up_count ? count + 4'h1 : count - 4'h1;
   end
endmodule // pudc_next_stage
`default_nettype wire

// ===== testbench/testbench.sv
// file: self-checking bench for the presettable up/down counter
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'h0;
   logic sys_rst = 1'h1;
   logic req = 1'h0;
   logic we = 1'h0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [3:0] sel = 4'hf;
   logic [31:0] dat_o;
   logic ack, irq;
   pudc_pkg::pudc_pins_in_t pins = 8'h30;
   pudc_pkg::pudc_pins_out_t pins_o;
   logic [3:0] hi_cnt, m, mh;
   logic [2:0] ms, mk;
   logic run;
   logic [31:0] r = 32'h0001_690b;
   logic ld, cl;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;

   always #50 clk = ~clk;

   pudc_counter uut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .pins_i(pins), .pins_o(pins_o), .irq(irq));
   pudc_next_stage next_u (.clk(clk), .sys_rst(sys_rst), .carry_in_n(pins_o.carry_out_n),
      .up_count(pins.up_count), .counter_clear(pins.counter_clear), .count(hi_cnt));

   // ---------------------------------------------------------------
   // reference model
   // ---------------------------------------------------------------
   // carry is only predicted with load and clear low; stimulus holding carry-in low under load or clear never shows a terminal count
   function automatic logic exp_co();
      return !(!pins.carry_in_n && run && !pins.load_enable && !pins.counter_clear &&
         ((pins.up_count && m == 4'hf) || (!pins.up_count && m == 4'h0)));
   endfunction

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         m = 4'h0;
         mh = 4'h0;
         ms = 3'h0;
         mk = 3'h0;
         run = 1'h1;
      end else begin
         if (!exp_co()) begin
            ms[0] = 1'h1;
            mh = pins.up_count ? mh + 4'h1 : mh - 4'h1;
         end
         if (pins.counter_clear) begin
            m = 4'h0;
            mh = 4'h0;
            ms[2] = 1'h1;
         end else if (pins.load_enable) begin
            m = pins[3:0];
            ms[1] = 1'h1;
         end else if (!pins.carry_in_n && run) m = pins.up_count ? m + 4'h1 : m - 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("errors %0d, compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      req <= 1'h1;
      we <= w;
      adr <= a;
      dat <= d;
      // no answer time assumed: only the cycle ceiling ends a hung wait
      do begin
         @(posedge clk);
      end while (ack !== 1'h1);
      q = dat_o;
      req <= 1'h0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'h0, a, 32'h0, q);
      check(q, e);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'h1, a, d, q);
   endtask

   // one pin cycle: drive at the edge, check the settled outputs mid-cycle
   task automatic step(input logic l, input logic c, input logic up, input logic ci, input logic [3:0] pr);
      @(posedge clk);
      pins <= {l, c, up, ci, pr};
      #50;
      check({28'h0, pins_o[3:0]}, {28'h0, c ? 4'h0 : l ? pr : m});
      check({31'h0, pins_o.carry_out_n}, {31'h0, exp_co()});
      check({28'h0, hi_cnt}, {28'h0, mh});
   endtask

   task automatic idle_irq();
      step(1'h0, 1'h0, 1'h1, 1'h1, 4'h0);
      step(1'h0, 1'h0, 1'h1, 1'h1, 4'h0);
      check({31'h0, irq}, {31'h0, (ms & mk) != 3'h0});
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         err_count++;
         results();
      end
   end

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'h0;
      rd(pudc_pkg::ADR_CTRL, 32'h1);
      rd(pudc_pkg::ADR_IRQ_MASK, 32'h0);
      rd(pudc_pkg::ADR_IRQ_STAT, 32'h0);
      rd(pudc_pkg::ADR_COUNT, 32'h0);
      wr(8'h20, 32'hffff_ffff);
      rd(8'h20, 32'h0);
      sel <= 4'he;
      wr(pudc_pkg::ADR_IRQ_MASK, 32'h7);
      sel <= 4'hf;
      rd(pudc_pkg::ADR_IRQ_MASK, 32'h0);
      // load with carry-in enabled must not count
      step(1'h1, 1'h0, 1'h1, 1'h0, 4'h5);
      step(1'h1, 1'h0, 1'h1, 1'h0, 4'h5);
      step(1'h1, 1'h0, 1'h1, 1'h1, 4'he);
      repeat (20) step(1'h0, 1'h0, 1'h1, 1'h0, 4'h0);
      step(1'h1, 1'h0, 1'h1, 1'h1, 4'hf);
      step(1'h0, 1'h0, 1'h1, 1'h1, 4'h0);
      step(1'h0, 1'h0, 1'h1, 1'h0, 4'h0);
      step(1'h1, 1'h0, 1'h0, 1'h1, 4'h2);
      repeat (20) step(1'h0, 1'h0, 1'h0, 1'h0, 4'h0);
      step(1'h1, 1'h1, 1'h1, 1'h1, 4'h9);
      step(1'h0, 1'h1, 1'h1, 1'h0, 4'h0);
      idle_irq();
      rd(pudc_pkg::ADR_IRQ_STAT, {29'h0, ms});
      wr(pudc_pkg::ADR_IRQ_MASK, 32'h7);
      mk = 3'h7;
      idle_irq();
      wr(pudc_pkg::ADR_IRQ_STAT, 32'h7);
      ms = 3'h0;
      idle_irq();
      step(1'h1, 1'h0, 1'h1, 1'h1, 4'hf);
      step(1'h0, 1'h0, 1'h1, 1'h0, 4'h0);
      idle_irq();
      rd(pudc_pkg::ADR_IRQ_STAT, {29'h0, ms});
      wr(pudc_pkg::ADR_IRQ_MASK, 32'h0);
      mk = 3'h0;
      idle_irq();
      rd(pudc_pkg::ADR_STAT, 32'h13);
      rd(pudc_pkg::ADR_COUNT, {28'h0, m});
      // stopped counter ignores enabled edges and keeps carry high
      wr(pudc_pkg::ADR_CTRL, 32'h0);
      run = 1'h0;
      step(1'h1, 1'h0, 1'h1, 1'h1, 4'hf);
      repeat (3) step(1'h0, 1'h0, 1'h1, 1'h0, 4'h0);
      step(1'h0, 1'h0, 1'h1, 1'h1, 4'h0);
      wr(pudc_pkg::ADR_CTRL, 32'h1);
      run = 1'h1;
      repeat (80) begin
         r = lfsr(r);
         ld = r[0] & r[1] & r[2];
         cl = r[3] & r[4] & r[5] & !ld;
         step(ld, cl, r[8], ld | cl | (r[6] & r[7]), r[12:9]);
      end
      // idle pins first, so neither load nor counting overrides the reset check
      step(1'h0, 1'h0, 1'h1, 1'h1, 4'h0);
      @(posedge clk);
      sys_rst <= 1'h1;
      #50;
      check({28'h0, pins_o[3:0]}, 32'h0);
      @(posedge clk);
      sys_rst <= 1'h0;
      rd(pudc_pkg::ADR_CTRL, 32'h1);
      rd(pudc_pkg::ADR_IRQ_STAT, 32'h0);
      results();
   end
endmodule // testbench
`default_nettype wire
